// ### design/pds_phy_duplex_status.sv
`timescale 1ns/1ps
`include "pds_regs.svh"
// Functional notes
// - Hardware mode takes duplex from select pin
// - Duplex status shows active link duplex
// - Software mode: negotiated duplex used when negotiation enabled
// - Software mode: control bit picks duplex
// - Loopback ignores the duplex control bit
// - Collision test off: COL not following TXEN
// - Collision test works even in loopback
// - COL rises within 512 bit times
// - COL falls within 4 bit times
// - Reserved control bits read zero
// - Status register 16 bits, defaults on reset
// - Four-pair capability bit reads zero
// - Capability bits reset to 8'hf0, override writable
// - Override enable gates capability writes
// - Negotiation complete latches high until read
// - Remote fault latches high until read
// - Latched bit holds until register read
module pds_phy_duplex_status import pds_pkg::*; #(
  parameter int COL_ON_CYC =
    (`PDS_COL_ON_BITS * `PDS_BIT_TIME_NS) / `PDS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Decoded management frames
  input wire pds_mgmt_req_t mgmt_req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Configuration pins
  input wire logic config_source_pin,
  input wire logic duplex_select_pin,
  input wire logic auto_neg_select_pin,
  input wire logic override_writable_en,
  // Line side status
  input wire logic an_done,
  input wire logic an_full_duplex,
  input wire logic remote_fault_in,
  input wire logic link_up,
  input wire logic jabber_in,
  // MII collision path
  input wire logic txen,
  input wire logic col_detect,
  output logic col,
  // Mode outputs
  output logic full_duplex,
  output logic duplex_status,
  output logic loopback_en,
  output logic auto_neg_en
);

  localparam int COL_OFF_CYC =
    (`PDS_COL_OFF_BITS * `PDS_BIT_TIME_NS) / `PDS_CLK_PERIOD_NS;

  localparam pds_state_t RST_STATE = '{
    loopback: 1'b0, an_en: 1'b0, duplex: 1'b0, col_test: 1'b0,
    cap: `PDS_CAP_RST, an_cplt: 1'b0, rfault: 1'b0, jabber: 1'b0,
    link: 1'b0, col: 1'b0, full_duplex: 1'b0,
    rd_data: `PDS_WORD_ZERO, rd_valid: 1'b0};

  pds_state_t s_reg;
  pds_state_t s_next;
  logic an_active;
  logic rd_stat;
  logic wr_ctrl;
  logic wr_stat;

  // ************************************************
  // Register words
  // ************************************************
  function automatic logic [15:0] ctrl_word(input pds_state_t s);
    logic [15:0] w;
    w = `PDS_WORD_ZERO;
    w[`PDS_CTRL_LOOPBACK] = s.loopback;
    w[`PDS_CTRL_AN_EN] = s.an_en;
    w[`PDS_CTRL_DUPLEX] = s.duplex;
    w[`PDS_CTRL_COL_TEST] = s.col_test;
    return w;
  endfunction

  function automatic logic [15:0] stat_word(input pds_state_t s);
    logic [15:0] w;
    w = `PDS_WORD_ZERO;
    w[`PDS_STAT_T4] = 1'b0;
    w[`PDS_STAT_CAP_HI:`PDS_STAT_CAP_LO] = s.cap;
    w[`PDS_STAT_AN_CPLT] = s.an_cplt;
    w[`PDS_STAT_RFAULT] = s.rfault;
    w[`PDS_STAT_AN_ABLE] = 1'b1;
    w[`PDS_STAT_LINK] = s.link;
    w[`PDS_STAT_JABBER] = s.jabber;
    w[`PDS_STAT_EXT] = 1'b1;
    return w;
  endfunction

  // ************************************************
  // Next state
  // ************************************************
  assign an_active = config_source_pin ? s_reg.an_en : auto_neg_select_pin;
  assign rd_stat = mgmt_req.valid && !mgmt_req.write &&
    mgmt_req.addr == `PDS_STAT_ADDR;
  assign wr_ctrl = mgmt_req.valid && mgmt_req.write &&
    mgmt_req.addr == `PDS_CTRL_ADDR;
  assign wr_stat = mgmt_req.valid && mgmt_req.write &&
    mgmt_req.addr == `PDS_STAT_ADDR;

  always_comb begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    // Read answers carry the latched values before the read clears them
    if (mgmt_req.valid && !mgmt_req.write) begin
      s_next.rd_valid = 1'b1;
      case (mgmt_req.addr)
        `PDS_CTRL_ADDR: s_next.rd_data = ctrl_word(s_reg);
        `PDS_STAT_ADDR: s_next.rd_data = stat_word(s_reg);
        default: s_next.rd_data = `PDS_WORD_ZERO;
      endcase
    end
    // A new event in the read cycle wins over the clear
    s_next.an_cplt = (an_done && an_active) ||
      (s_reg.an_cplt && !rd_stat);
    s_next.rfault = remote_fault_in ||
      (s_reg.rfault && !rd_stat);
    s_next.jabber = jabber_in || (s_reg.jabber && !rd_stat);
    s_next.link = link_up && (s_reg.link || rd_stat);
    if (wr_ctrl) begin
      s_next.loopback = mgmt_req.wdata[`PDS_CTRL_LOOPBACK];
      s_next.an_en = mgmt_req.wdata[`PDS_CTRL_AN_EN];
      s_next.duplex = mgmt_req.wdata[`PDS_CTRL_DUPLEX];
      s_next.col_test = mgmt_req.wdata[`PDS_CTRL_COL_TEST];
    end
    if (wr_stat && override_writable_en) begin
      s_next.cap =
        mgmt_req.wdata[`PDS_STAT_CAP_HI:`PDS_STAT_CAP_LO];
    end
    // Duplex selection
    if (!config_source_pin) begin
      s_next.full_duplex = duplex_select_pin;
    end else if (s_reg.an_en) begin
      s_next.full_duplex = an_full_duplex;
    end else if (s_reg.loopback) begin
      s_next.full_duplex = `PDS_LOOPBACK_DUPLEX;
    end else begin
      s_next.full_duplex = s_reg.duplex;
    end
    // Collision test tracks TXEN one cycle late, far inside both limits
    if (s_reg.col_test) begin
      s_next.col = txen;
    end else begin
      s_next.col = col_detect && !s_reg.loopback;
    end
    // Soft reset self-clears: defaults load in one cycle
    if (wr_ctrl && mgmt_req.wdata[`PDS_CTRL_RESET]) begin
      s_next = RST_STATE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;
  assign col = s_reg.col;
  assign full_duplex = s_reg.full_duplex;
  assign duplex_status = s_reg.full_duplex;
  assign loopback_en = s_reg.loopback;
  assign auto_neg_en = an_active;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  localparam int COL_ON_BOUND = 2;
  localparam int COL_OFF_BOUND = 2;

  col_on_test_a: assert property (
    s_reg.col_test && txen && !wr_ctrl ##1 txen |-> ##[0:COL_ON_BOUND] col)
    else $error("COL late after TXEN in collision test");
  col_off_test_a: assert property (
    s_reg.col_test && !txen && !wr_ctrl ##1 !txen |->
      ##[0:COL_OFF_BOUND] !col)
    else $error("COL held after TXEN fell in collision test");
  col_test_idle_a: assert property (
    !s_reg.col_test && !col_detect |=> !col)
    else $error("COL followed TXEN without collision test");
  col_loop_test_a: assert property (
    s_reg.loopback && s_reg.col_test && txen |=> col)
    else $error("Collision test blocked by loopback");
  dpx_hw_pin_a: assert property (
    !config_source_pin && !wr_ctrl |=>
      full_duplex == $past(duplex_select_pin))
    else $error("Hardware mode duplex not from pin");
  dpx_an_res_a: assert property (
    config_source_pin && s_reg.an_en && !wr_ctrl |=>
      full_duplex == $past(an_full_duplex))
    else $error("Negotiated duplex not used");
  dpx_sw_bit_a: assert property (
    config_source_pin && !s_reg.an_en && !s_reg.loopback && !wr_ctrl |=>
      full_duplex == $past(s_reg.duplex))
    else $error("Software duplex bit not applied");
  dpx_loop_fix_a: assert property (
    config_source_pin && !s_reg.an_en && s_reg.loopback && !wr_ctrl |=>
      full_duplex == `PDS_LOOPBACK_DUPLEX)
    else $error("Duplex bit affected loopback");
  rsvd_ctrl_zero_a: assert property (
    mgmt_req.valid && !mgmt_req.write &&
      mgmt_req.addr == `PDS_CTRL_ADDR |=>
      rd_valid && rd_data[`PDS_CTRL_RSVD_HI:`PDS_CTRL_RSVD_LO] == '0)
    else $error("Reserved control bits read nonzero");
  stat_const_a: assert property (
    rd_stat |=> rd_valid && !rd_data[`PDS_STAT_T4] &&
      rd_data[`PDS_STAT_AN_ABLE] && rd_data[`PDS_STAT_EXT])
    else $error("Status constant bits wrong");
  cap_lock_a: assert property (
    wr_stat && !override_writable_en && !wr_ctrl |=> $stable(s_reg.cap))
    else $error("Capability bits written without override");
  cap_write_a: assert property (
    wr_stat && override_writable_en |=>
      s_reg.cap == $past(mgmt_req.wdata[`PDS_STAT_CAP_HI:`PDS_STAT_CAP_LO]))
    else $error("Override write did not take effect");
  soft_rst_a: assert property (
    wr_ctrl && mgmt_req.wdata[`PDS_CTRL_RESET] |=>
      s_reg.cap == `PDS_CAP_RST && !s_reg.an_cplt && !s_reg.col_test)
    else $error("Soft reset did not load defaults");
  an_hold_a: assert property (
    s_reg.an_cplt && !rd_stat && !wr_ctrl |=> s_reg.an_cplt)
    else $error("Negotiation complete dropped before read");
  rf_hold_a: assert property (
    s_reg.rfault && !rd_stat && !wr_ctrl |=> s_reg.rfault)
    else $error("Remote fault dropped before read");
  lh_clear_a: assert property (
    rd_stat && !remote_fault_in && !wr_ctrl |=> !s_reg.rfault)
    else $error("Latched bit not cleared by read");
  link_low_a: assert property (
    !link_up && !wr_ctrl |=> !s_reg.link ##1 (!s_reg.link || $past(rd_stat)))
    else $error("Link loss not latched low");

  col_test_c: cover property (s_reg.col_test && txen ##1 col ##1 !txen);
  stat_read_c: cover property (rd_stat && s_reg.an_cplt ##1 rd_valid);
  cap_write_c: cover property (wr_stat && override_writable_en);
  hw_mode_c: cover property (!config_source_pin && duplex_select_pin);

endmodule

// ### design/pds_pkg.sv
package pds_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pds_mgmt_req_t;

  typedef struct packed {
    logic loopback;
    logic an_en;
    logic duplex;
    logic col_test;
    logic [7:0] cap;
    logic an_cplt;
    logic rfault;
    logic jabber;
    logic link;
    logic col;
    logic full_duplex;
    logic [15:0] rd_data;
    logic rd_valid;
  } pds_state_t;

endpackage

// ### design/pds_regs.svh
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

// ************************************************
// Register addresses
// ************************************************
`define PDS_CTRL_ADDR 5'h00
`define PDS_STAT_ADDR 5'h01

// ************************************************
// Control register fields
// ************************************************
`define PDS_CTRL_RESET 15
`define PDS_CTRL_LOOPBACK 14
`define PDS_CTRL_AN_EN 12
`define PDS_CTRL_DUPLEX 8
`define PDS_CTRL_COL_TEST 7
`define PDS_CTRL_RSVD_HI 6
`define PDS_CTRL_RSVD_LO 0

// ************************************************
// Status register fields
// ************************************************
`define PDS_STAT_T4 15
`define PDS_STAT_CAP_HI 14
`define PDS_STAT_CAP_LO 7
`define PDS_STAT_PRE_SUP 6
`define PDS_STAT_AN_CPLT 5
`define PDS_STAT_RFAULT 4
`define PDS_STAT_AN_ABLE 3
`define PDS_STAT_LINK 2
`define PDS_STAT_JABBER 1
`define PDS_STAT_EXT 0

// ************************************************
// Reset values
// ************************************************
`define PDS_CAP_RST 8'hf0
`define PDS_WORD_ZERO 16'h0000
`define PDS_LOOPBACK_DUPLEX 1'b1

// ************************************************
// Timing
// ************************************************
`define PDS_CLK_PERIOD_NS 5
`define PDS_BIT_TIME_NS 100
`define PDS_COL_ON_BITS 512
`define PDS_COL_OFF_BITS 4

`endif

// ### test/pds_sta_model.sv
`timescale 1ns/1ps
// ************************************************
// Station manager model
// ************************************************
module pds_sta_model import pds_pkg::*; (
  // Clock
  input wire logic clk,
  // Management frames
  output pds_mgmt_req_t mgmt_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial mgmt_req = '0;
  // Idle fields carry inverted junk so stale values never pass
  task automatic req(input logic w, input logic [4:0] a,
      input logic [15:0] d);
    @(negedge clk);
    mgmt_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clk);
    mgmt_req = ~mgmt_req;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == 5'h00) begin
      d = d & 16'hff80;
    end
    if (a == 5'h01) begin
      d = d & 16'hf87f;
    end
    req(1'b1, a, d);
  endtask
  // Answer is looked at in its one valid cycle only
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    req(1'b0, a, 16'h0000);
    q = rd_valid ? rd_data : 16'hxxxx;
  endtask
endmodule

// ### test/phy_duplex_collision_status_regs_tb.sv
`timescale 1ns/1ps
// ************************************************
// Testbench
// ************************************************
module phy_duplex_collision_status_regs_tb;
  import pds_pkg::*;
  logic clk, rst_b, config_source_pin, duplex_select_pin;
  logic auto_neg_select_pin, override_writable_en, an_done;
  logic an_full_duplex, remote_fault_in, link_up, jabber_in;
  logic txen, col_detect, rd_valid, col, full_duplex, duplex_status;
  logic loopback_en, auto_neg_en;
  logic [15:0] rd_data, q;
  logic [7:0] cap;
  logic [5:0] p;
  pds_mgmt_req_t mgmt_req;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 46702;

  pds_sta_model sta (.clk, .mgmt_req, .rd_data, .rd_valid);
  pds_phy_duplex_status #(.COL_ON_CYC(16)) DUT (.clk, .rst_b,
    .mgmt_req, .rd_data, .rd_valid, .config_source_pin,
    .duplex_select_pin, .auto_neg_select_pin, .override_writable_en,
    .an_done, .an_full_duplex, .remote_fault_in, .link_up, .jabber_in,
    .txen, .col_detect, .col, .full_duplex, .duplex_status,
    .loopback_en, .auto_neg_en);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // v holds negotiation done, remote fault, link, jabber
  function automatic logic [15:0] stat(input logic [7:0] c,
      input logic [3:0] v);
    return {1'b0, c, 1'b0, v[3], v[2], 1'b1, v[1], v[0], 1'b1};
  endfunction
  // p holds source, select pin, negotiation, loopback, bit, result
  function automatic logic fd(input logic [5:0] p);
    if (!p[5]) return p[4];
    if (p[3]) return p[0];
    if (p[2]) return 1'b1;
    return p[1];
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {config_source_pin, duplex_select_pin, auto_neg_select_pin} = '0;
    {override_writable_en, an_done, an_full_duplex} = '0;
    {remote_fault_in, link_up, jabber_in, txen, col_detect} = '0;
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'h0));
    sta.rd(5'h00, q);
    chk(q, 16'h0000);
    sta.rd(5'h05, q);
    chk(q, 16'h0000);
    $display("test defaults done");
    for (int i = 0; i < 24; i++) begin
      p = 6'($random(seed));
      {config_source_pin, duplex_select_pin} = p[5:4];
      an_full_duplex = p[0];
      auto_neg_select_pin = 1'($random(seed));
      sta.wr(5'h00, {1'b0, p[2], 1'b0, p[3], 3'h0, p[1], 8'h7f});
      repeat (2) @(negedge clk);
      chk(16'(full_duplex), 16'(fd(p)));
      chk(16'(duplex_status), 16'(fd(p)));
      chk(16'(loopback_en), 16'(p[2]));
      chk(16'(auto_neg_en), 16'(p[5] ? p[3] : auto_neg_select_pin));
      sta.rd(5'h00, q);
      chk(q & 16'h507f, {1'b0, p[2], 1'b0, p[3], 12'h000});
    end
    $display("test duplex done");
    for (int k = 0; k < 4; k++) begin
      sta.wr(5'h00, {1'b0, k[0], 6'h00, k[1], 7'h00});
      txen = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(col), 16'(k[1]));
      txen = 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(col), 16'h0000);
      // Line collision passes only with test off and loopback off
      col_detect = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(col), 16'(!k[1] && !k[0]));
      col_detect = 1'b0;
      repeat (2) @(negedge clk);
    end
    $display("test collision done");
    sta.wr(5'h01, 16'h0000);
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'h0));
    override_writable_en = 1'b1;
    sta.wr(5'h01, 16'hffff);
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'h0));
    cap = {4'($random(seed)), 4'h0};
    sta.wr(5'h01, {1'b0, cap, 7'h00});
    sta.rd(5'h01, q);
    chk(q, stat(cap, 4'h0));
    sta.wr(5'h00, 16'h8000);
    @(negedge clk);
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'h0));
    $display("test override done");
    config_source_pin = 1'b1;
    sta.wr(5'h00, 16'h1000);
    link_up = 1'b1;
    {an_done, remote_fault_in, jabber_in} = 3'b111;
    @(negedge clk);
    {an_done, remote_fault_in, jabber_in} = 3'b000;
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'b1101));
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'b0010));
    link_up = 1'b0;
    @(negedge clk);
    link_up = 1'b1;
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'b0000));
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'b0010));
    $display("test latches done");
    sta.wr(5'h01, 16'h0000);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    sta.rd(5'h01, q);
    chk(q, stat(8'hf0, 4'h0));
    $display("test reset done");
    stop_test;
  end

  initial begin
    #100000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
